/* File: shared/chi_defs.vh */
`ifndef CHI_DEFS_VH
`define CHI_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CHI_OFS_CTRL 8'h00
`define CHI_OFS_MODE 8'h04
`define CHI_OFS_DTO 8'h08
`define CHI_OFS_SLOT 8'h0C
`define CHI_OFS_ARG 8'h10
`define CHI_OFS_CMD 8'h14
`define CHI_OFS_RSP0 8'h20
`define CHI_OFS_RSP3 8'h2C
`define CHI_OFS_RDATA 8'h30
`define CHI_OFS_STAT 8'h40
`define CHI_OFS_BLKDONE 8'h50
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CHI_MR_PADV 14
`define CHI_MR_DMAM 15
`define CHI_MR_MASK 32'h3FFCC7FF
`define CHI_DTO_MASK 32'h0000007F
`define CHI_SD_MASK 32'h00000081
`define CHI_CR_EN 0
`define CHI_CR_DIS 1
`define CHI_CR_PSEN 2
`define CHI_CR_PSDIS 3
`define CHI_ST_COMMAND_READY 0
`define CHI_ST_RTOE 20
`define CHI_ST_DTOE 22
`define CHI_ST_OVERRUN_FLAG 30
`define CHI_ST_UNDERRUN_FLAG 31
// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define CHI_SP_NONE 3'h0
`define CHI_SP_INIT 3'h1
`define CHI_SP_SYNC 3'h2
`define CHI_SP_INTCMD 3'h4
`define CHI_SP_INTRSP 3'h5
`define CHI_INIT_CLKS 7'h4A
`define CHI_LAT_SHORT 7'h05
`define CHI_LAT_LONG 7'h40
`define CHI_RSP_NONE 2'h0
`define CHI_RSP_48 2'h1
`define CHI_RSP_136 2'h2
`endif

/* File: design/chi_clkgen.v */
`include "chi_defs.vh"
// Card clock enable: core / (2*(div+1)), then / 2^psdiv in power save
module chi_clkgen (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] clk_div,
  input wire [2:0] ps_div,
  input wire ps_on,
  output reg card_clock,
  output reg tick
);
  reg [7:0] cnt;
  reg [6:0] ps_cnt;
  wire [6:0] ps_lim;
  wire half;
  assign ps_lim = ps_on ? ((7'h01 << ps_div) - 7'h01) : 7'h00;
  assign half = (cnt == clk_div);
  // ----------------------------------------
  // Divider chain
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      ps_cnt <= 7'h00;
      card_clock <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (half) begin
        cnt <= 8'h00;
        if (ps_cnt >= ps_lim) begin
          ps_cnt <= 7'h00;
          card_clock <= ~card_clock;
          tick <= card_clock; // Falling edge, one pulse per period
        end else begin
          ps_cnt <= ps_cnt + 7'h01;
        end
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

/* File: design/chi_timeout.v */
`include "chi_defs.vh"
// Data timeout: cycles x multiplier master clocks between blocks
module chi_timeout (
  input wire core_clk,
  input wire resetn,
  input wire run,
  input wire restart,
  input wire [3:0] cyc,
  input wire [2:0] mul,
  output reg expired
);
  reg [24:0] cnt;
  wire [24:0] limit;
  // Multiplier decode
  function [20:0] mul_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: mul_of = 21'h000001;
        3'h1: mul_of = 21'h000010;
        3'h2: mul_of = 21'h000080;
        3'h3: mul_of = 21'h000100;
        3'h4: mul_of = 21'h000400;
        3'h5: mul_of = 21'h001000;
        3'h6: mul_of = 21'h010000;
        default: mul_of = 21'h100000;
      endcase
    end
  endfunction
  assign limit = {4'h0, mul_of(mul)} * {21'h000000, cyc};
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 25'h0000000;
      expired <= 1'b0;
    end else if (restart || !run) begin
      cnt <= 25'h0000000;
      expired <= 1'b0;
    end else if (cnt >= limit) begin
      expired <= 1'b1;
    end else begin
      cnt <= cnt + 25'h0000001;
    end
  end
endmodule

/* File: design/chi_host_cfg.v */
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`include "chi_defs.vh"
// Notes on behaviour
// - Card clock is master over 2*(div+1)
// - Power save divides further by 2^psdiv
// - Write padding byte 0x00 or 0xFF
// - DMA mode disables underrun and overrun flags
// - Block length sized; bits 16,17 forced zero
// - Data timeout after cycles times multiplier
// - Multiplier codes map 1 to 1048576
// - Slot A/B and 1/4-bit bus select
// - Command writes ignored while busy or interrupted
// - Init command emits 74 card clocks first
// - Synchronized command waits for block end
// - Interrupt command and response codes supported
// - Command line open-drain or push-pull
// - Response timeout after 5 or 64 cycles
// - Commands other than init and synchronized start right after register write
// - Response captured into four readable words
// - Command ready set when sent, or when the response ends or times out, cleared on write
module chi_host_cfg (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire card_clock,
  output wire slot_b_select,
  output wire wide_bus,
  output reg cmd_out,
  output reg cmd_oe,
  input wire cmd_in,
  input wire [7:0] rx_byte,
  input wire rx_byte_valid,
  input wire block_end,
  input wire data_underrun,
  input wire data_overrun,
  output wire [15:0] block_length,
  output wire [7:0] pad_byte,
  output wire dma_oriented_mode,
  output wire [1:0] transfer_action,
  output wire transfer_direction,
  output wire [1:0] transfer_kind,
  output reg transfer_start
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] card_mode_config;
  reg [31:0] data_timeout_config;
  reg [31:0] card_slot_bus_config;
  reg [31:0] command_argument;
  reg [31:0] command_issue;
  reg [31:0] receive_data_word;
  reg [127:0] card_response;
  reg [1:0] rsp_ptr;
  reg enabled;
  reg ps_mode;
  reg command_ready;
  reg int_lock;
  reg rtoe;
  reg dtoe;
  reg overrun_flag;
  reg underrun_flag;
  reg blk_seen;
  reg ack;
  reg cmd_in_s1;
  reg cmd_in_s2;
  reg [2:0] state;
  reg [7:0] bitcnt;
  reg [47:0] shreg;
  reg [6:0] waitcnt;
  wire tick;
  wire dto_hit;
  wire sel_cmd;
  wire cmd_accept;
  wire [2:0] special_command_kind;
  wire [1:0] response_kind;
  wire [31:0] wmask;
  wire [31:0] status_word;
  localparam ST_IDLE = 3'h0;
  localparam ST_INIT = 3'h1;
  localparam ST_SYNC = 3'h2;
  localparam ST_SEND = 3'h3;
  localparam ST_WAIT = 3'h4;
  localparam ST_RECV = 3'h5;
  // Byte-enable write mask
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction
  // Merge a masked write into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction
  // Response bit length by kind
  function [7:0] rsp_bits;
    input [1:0] k;
    begin
      case (k)
        `CHI_RSP_48: rsp_bits = 8'd48;
        `CHI_RSP_136: rsp_bits = 8'd136;
        default: rsp_bits = 8'd0;
      endcase
    end
  endfunction
  assign special_command_kind = command_issue[10:8];
  assign response_kind = command_issue[7:6];
  assign transfer_action = command_issue[17:16];
  assign transfer_direction = command_issue[18];
  assign transfer_kind = command_issue[20:19];
  assign block_length = {2'b00,
    card_mode_config[29:16]};
  assign pad_byte = card_mode_config[`CHI_MR_PADV] ? 8'hFF : 8'h00;
  assign dma_oriented_mode = card_mode_config[`CHI_MR_DMAM];
  assign slot_b_select = card_slot_bus_config[0];
  assign wide_bus = card_slot_bus_config[7];
  // Single-cycle wait on reads so data comes from a flop
  assign avs_waitrequest = avs_read & ~ack;
  assign wmask = be_mask(avs_byteenable);
  assign sel_cmd = avs_write && (avs_address == `CHI_OFS_CMD);
  assign cmd_accept = sel_cmd && command_ready && !int_lock;
  assign status_word = {underrun_flag, overrun_flag, 7'h00, dtoe, 1'b0, rtoe, 16'h0000,
    blk_seen, 2'b00, command_ready};

  chi_clkgen u_clk (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_div(card_mode_config[7:0]),
    .ps_div(card_mode_config[10:8]),
    .ps_on(ps_mode),
    .card_clock(card_clock),
    .tick(tick)
  );

  chi_timeout u_dto (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(transfer_action == 2'h1 && enabled),
    .restart(block_end | transfer_start),
    .cyc(data_timeout_config[3:0]),
    .mul(data_timeout_config[6:4]),
    .expired(dto_hit)
  );

  // ----------------------------------------
  // Response line synchroniser
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_in_s1 <= 1'b1;
      cmd_in_s2 <= 1'b1;
    end else begin
      cmd_in_s1 <= cmd_in;
      cmd_in_s2 <= cmd_in_s1;
    end
  end

  // Register writes and read data
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      card_mode_config <= 32'h00000000;
      data_timeout_config <= 32'h00000000;
      card_slot_bus_config <= 32'h00000000;
      command_argument <= 32'h00000000;
      enabled <= 1'b0;
      ps_mode <= 1'b0;
      avs_readdata <= 32'h00000000;
      ack <= 1'b0;
      rsp_ptr <= 2'h0;
      blk_seen <= 1'b0;
      receive_data_word <= 32'h00000000;
    end else begin
      ack <= avs_read & ~ack;
      if (rx_byte_valid)
        receive_data_word <= {receive_data_word[23:0], rx_byte};
      if (block_end)
        blk_seen <= 1'b1;
      if (avs_write) begin
        case (avs_address)
          `CHI_OFS_CTRL: begin
            if (avs_writedata[`CHI_CR_DIS])
              enabled <= 1'b0;
            else if (avs_writedata[`CHI_CR_EN])
              enabled <= 1'b1;
            if (avs_writedata[`CHI_CR_PSDIS])
              ps_mode <= 1'b0;
            else if (avs_writedata[`CHI_CR_PSEN])
              ps_mode <= 1'b1;
          end
          `CHI_OFS_MODE: card_mode_config <= merge(card_mode_config,
            avs_writedata, wmask & `CHI_MR_MASK);
          `CHI_OFS_DTO: data_timeout_config <= merge(data_timeout_config,
            avs_writedata, wmask & `CHI_DTO_MASK);
          `CHI_OFS_SLOT: card_slot_bus_config <= merge(card_slot_bus_config,
            avs_writedata, wmask & `CHI_SD_MASK);
          `CHI_OFS_ARG: command_argument <= merge(command_argument,
            avs_writedata, wmask);
          default: ;
        endcase
      end
      if (cmd_accept)
        rsp_ptr <= 2'h0;
      if (avs_read && !ack) begin
        case (avs_address)
          `CHI_OFS_MODE: avs_readdata <= card_mode_config;
          `CHI_OFS_DTO: avs_readdata <= data_timeout_config;
          `CHI_OFS_SLOT: avs_readdata <= card_slot_bus_config;
          `CHI_OFS_ARG: avs_readdata <= command_argument;
          `CHI_OFS_RDATA: avs_readdata <= receive_data_word;
          `CHI_OFS_STAT: begin
            avs_readdata <= status_word;
            if (!block_end)
              blk_seen <= 1'b0;
          end
          `CHI_OFS_BLKDONE: avs_readdata <= {31'h0, blk_seen};
          default: begin
            if (avs_address >= `CHI_OFS_RSP0 &&
                avs_address <= `CHI_OFS_RSP3) begin
              // Successive reads walk the response words
              case (rsp_ptr)
                2'h0: avs_readdata <= card_response[127:96];
                2'h1: avs_readdata <= card_response[95:64];
                2'h2: avs_readdata <= card_response[63:32];
                default: avs_readdata <= card_response[31:0];
              endcase
              rsp_ptr <= rsp_ptr + 2'h1;
            end else begin
              avs_readdata <= 32'h00000000;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Error flags, hardware set wins over clear
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dtoe <= 1'b0;
      overrun_flag <= 1'b0;
      underrun_flag <= 1'b0;
    end else begin
      if (cmd_accept)
        dtoe <= 1'b0;
      if (dto_hit)
        dtoe <= 1'b1;
      if (transfer_start) begin
        overrun_flag <= 1'b0;
        underrun_flag <= 1'b0;
      end
      if (data_overrun && !dma_oriented_mode)
        overrun_flag <= 1'b1;
      if (data_underrun && !dma_oriented_mode)
        underrun_flag <= 1'b1;
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      command_issue <= 32'h00000000;
      command_ready <= 1'b1;
      int_lock <= 1'b0;
      rtoe <= 1'b0;
      state <= ST_IDLE;
      bitcnt <= 8'h00;
      shreg <= 48'h000000000000;
      waitcnt <= 7'h00;
      card_response <= 128'h0;
      cmd_out <= 1'b1;
      cmd_oe <= 1'b0;
      transfer_start <= 1'b0;
    end else begin
      transfer_start <= 1'b0;
      if (cmd_accept) begin
        command_issue <= avs_writedata & 32'h001F1FFF;
        command_ready <= 1'b0;
        rtoe <= 1'b0;
        shreg <= {2'b01, avs_writedata[5:0], command_argument,
          8'h01};
        bitcnt <= 8'd48;
        case (avs_writedata[10:8])
          `CHI_SP_INIT: begin
            state <= ST_INIT;
            bitcnt <= {1'b0, `CHI_INIT_CLKS};
          end
          `CHI_SP_SYNC: state <= ST_SYNC;
          `CHI_SP_INTCMD, `CHI_SP_INTRSP: begin
            state <= ST_SEND;
            int_lock <= 1'b1;
          end
          default: state <= ST_SEND;
        endcase
      end else begin
        case (state)
          ST_IDLE: cmd_oe <= 1'b0;
          ST_INIT: if (tick) begin
            cmd_oe <= 1'b0;
            if (bitcnt == 8'd1) begin
              state <= ST_SEND;
              bitcnt <= 8'd48;
            end else begin
              bitcnt <= bitcnt - 8'd1;
            end
          end
          ST_SYNC: if (block_end) state <= ST_SEND;
          ST_SEND: if (tick) begin
            cmd_out <= shreg[47];
            // Open drain only pulls low
            cmd_oe <= special_command_kind == `CHI_SP_INTRSP ? 1'b0 :
              (command_issue[11] ? ~shreg[47] : 1'b1);
            shreg <= {shreg[46:0], 1'b1};
            if (bitcnt == 8'd1) begin
              waitcnt <= 7'h00;
              if (transfer_action == 2'h1)
                transfer_start <= 1'b1;
              if (response_kind == `CHI_RSP_NONE ||
                  response_kind == 2'h3) begin
                state <= ST_IDLE;
                command_ready <= 1'b1;
              end else begin
                state <= ST_WAIT;
              end
            end
            bitcnt <= bitcnt - 8'd1;
          end
          ST_WAIT: if (tick) begin
            cmd_oe <= 1'b0;
            if (!cmd_in_s2) begin
              state <= ST_RECV;
              bitcnt <= rsp_bits(response_kind) - 8'd1;
              card_response <= 128'h0;
            end else if (waitcnt == (command_issue[12] ?
                `CHI_LAT_LONG : `CHI_LAT_SHORT)) begin
              rtoe <= 1'b1;
              state <= ST_IDLE;
              command_ready <= 1'b1;
            end else begin
              waitcnt <= waitcnt + 7'h01;
            end
          end
          ST_RECV: if (tick) begin
            card_response <= {card_response[126:0], cmd_in_s2};
            if (bitcnt == 8'd1) begin
              state <= ST_IDLE;
              command_ready <= 1'b1;
            end
            bitcnt <= bitcnt - 8'd1;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

/* File: bench/chi_host_cfg_checker.sv */
module chi_host_cfg_checker (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire slot_b_select,
  input wire wide_bus,
  input wire cmd_out,
  input wire cmd_oe,
  input wire [15:0] block_length,
  input wire [7:0] pad_byte,
  input wire dma_oriented_mode,
  input wire transfer_start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // -----------------------------------
  // Port checks
  // -----------------------------------
  wire wr_mode = avs_write && avs_address == 8'h04;
  wire wr_slot = avs_write && avs_address == 8'h0C;
  reg od_sel;
  // Open-drain bit of the last command write
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      od_sel <= 1'b0;
    else if (avs_write && avs_address == 8'h14)
      od_sel <= avs_writedata[11];
  end
  a_write_no_wait: assert property (
    avs_write |-> !avs_waitrequest) else $error("write stalled");
  a_read_one_wait: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait wrong");
  a_pad_value: assert property (
    wr_mode |=> pad_byte == {8{$past(avs_writedata[14])}})
    else $error("pad byte wrong");
  a_dma_mode: assert property (
    wr_mode |=> dma_oriented_mode == $past(avs_writedata[15]))
    else $error("dma mode wrong");
  a_block_len: assert property (
    wr_mode |=> block_length == ($past(avs_writedata[31:16]) & 16'h3FFC))
    else $error("block length wrong");
  a_slot_bus: assert property (
    wr_slot |=> slot_b_select == $past(avs_writedata[0]) &&
    wide_bus == $past(avs_writedata[7])) else $error("slot or bus wrong");
  a_open_drain: assert property (
    od_sel && cmd_oe |-> !cmd_out) else $error("open drain drove high");
  a_start_pulse: assert property (
    transfer_start |=> !transfer_start) else $error("start not a pulse");
  a_data_hold: assert property (
    !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
endmodule

bind chi_host_cfg chi_host_cfg_checker u_chk (
  .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .slot_b_select(slot_b_select),
  .wide_bus(wide_bus), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
  .block_length(block_length), .pad_byte(pad_byte),
  .dma_oriented_mode(dma_oriented_mode), .transfer_start(transfer_start));

/* File: bench/chi_card_model.sv */
module chi_card_model (
  input wire card_clock,
  input wire cmd_out,
  input wire cmd_oe,
  output wire cmd_in,
  output reg [47:0] frame = 48'h0,
  output reg [7:0] start_cnt = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [47:0] sh = 48'h0;
  reg [47:0] rsp = {48{1'b1}};
  reg [5:0] nbit = 6'h00;
  reg go = 1'b0;
  wire host_line;
  // Host side of the line, pulled up when released
  assign host_line = cmd_oe ? cmd_out : 1'b1;
  // Card answers index 3 only, one clock after the host frame
  assign cmd_in = cmd_oe ? cmd_out : rsp[47];
  // Capture each 48-bit host frame and shift out any response
  always @(posedge card_clock) begin
    rsp <= go ? 48'h0389ABCDEF01 : {rsp[46:0], 1'b1};
    go <= 1'b0;
    if (nbit == 6'h00 && host_line === 1'b0) begin
      nbit <= 6'h01;
      start_cnt <= start_cnt + 8'h01;
      sh <= 48'h0;
    end else if (nbit != 6'h00) begin
      sh <= {sh[46:0], host_line};
      nbit <= (nbit == 6'h2F) ? 6'h00 : nbit + 6'h01;
      if (nbit == 6'h2F) begin
        frame <= {sh[46:0], host_line};
        go <= (sh[44:39] == 6'h03);
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [7:0] rx_byte = 8'h00;
  reg rx_byte_valid = 1'b0;
  reg block_end = 1'b0;
  reg data_underrun = 1'b0;
  reg data_overrun = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, card_clock, slot_b_select, wide_bus, cmd_out;
  wire cmd_oe, cmd_in, dma_oriented_mode, transfer_direction, transfer_start;
  wire [15:0] block_length;
  wire [7:0] pad_byte, start_cnt;
  wire [1:0] transfer_action, transfer_kind;
  wire [47:0] frame;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int ccnt = 0;
  int n_start = 0;
  int lat, dur, s;
  reg [31:0] rd_val;
  chi_host_cfg dut (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .card_clock(card_clock), .slot_b_select(slot_b_select),
    .wide_bus(wide_bus), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
    .cmd_in(cmd_in), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .block_end(block_end), .data_underrun(data_underrun),
    .data_overrun(data_overrun), .block_length(block_length),
    .pad_byte(pad_byte), .dma_oriented_mode(dma_oriented_mode),
    .transfer_action(transfer_action),
    .transfer_direction(transfer_direction), .transfer_kind(transfer_kind),
    .transfer_start(transfer_start));
  chi_card_model card (.card_clock(card_clock), .cmd_out(cmd_out),
    .cmd_oe(cmd_oe), .cmd_in(cmd_in), .frame(frame), .start_cnt(start_cnt));
  // Master clock
  always #20 core_clk = ~core_clk;
  // Card clock edge count
  always @(posedge card_clock) ccnt <= ccnt + 1;
  // Transfer start pulse count
  always @(posedge core_clk) if (transfer_start) n_start <= n_start + 1;
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      end_sim;
    end
  end
  // -----------------------------------
  // Bus and check tasks
  // -----------------------------------
  task end_sim;
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_val = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task rdy;
    do rd(8'h40); while (rd_val[0] !== 1'b1);
  endtask
  task blk;
    @(posedge core_clk);
    block_end <= 1'b1;
    @(posedge core_clk);
    block_end <= 1'b0;
  endtask
  task issue(input [31:0] c);
    int c0;
    s = start_cnt;
    c0 = ccnt;
    wr(8'h14, c);
    while (start_cnt == s) @(posedge card_clock);
    lat = ccnt - c0;
    c0 = ccnt;
    rdy;
    dur = ccnt - c0;
  endtask
  task clk_per(input int e);
    int n;
    bit lo;
    n = 0;
    lo = 1'b0;
    repeat (2) @(posedge card_clock);
    do begin
      @(negedge core_clk);
      n++;
      if (card_clock === 1'b0)
        lo = 1'b1;
    end while (!lo || card_clock !== 1'b1);
    check("card period", n - 1, e);
  endtask
  // -----------------------------------
  // Scenarios
  // -----------------------------------
  task t_regs;
    reg [7:0] ra [5];
    ra = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      check("reset value", rd_val, 32'h0);
    end
    rd(8'h40);
    check("ready", rd_val[0], 1'b1);
    wr(8'h10, 32'hA5C30F1E);
    rd(8'h10);
    check("arg", rd_val, 32'hA5C30F1E);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C);
    check("slot", {rd_val[29:0], slot_b_select, wide_bus}, 32'h207);
  endtask
  task t_mode;
    wr(8'h04, 32'h3FFFFFFF);
    rd(8'h04);
    check("mode", rd_val, 32'h3FFCC7FF);
    check("blk len", block_length, 16'h3FFC);
    check("pad dma", {pad_byte, dma_oriented_mode}, 9'h1FF);
    wr(8'h04, 32'h01230002);
    rd(8'h04);
    check("mode", rd_val, 32'h01200002);
    check("pad dma", {pad_byte, dma_oriented_mode}, 9'h000);
  endtask
  task t_clk;
    wr(8'h00, 32'h1);
    clk_per(6);
    wr(8'h04, 32'h01200102);
    wr(8'h00, 32'h4);
    clk_per(12);
    wr(8'h00, 32'h8);
    clk_per(6);
  endtask
  task t_cmd;
    wr(8'h14, 32'h42);
    rd(8'h40);
    check("busy", rd_val[0], 1'b0);
    wr(8'h14, 32'h05);
    rdy;
    check("index", frame[45:40], 6'h02);
    check("arg sent", frame[39:8], 32'hA5C30F1E);
    check("frames", start_cnt, 8'h01);
    rd(8'h40);
    check("rsp timeout", rd_val[20], 1'b1);
    issue(32'h1042);
    check("start", lat <= 4, 1'b1);
    check("long wait", dur inside {[108:122]}, 1'b1);
    issue(32'h82);
    check("short wait", dur inside {[50:62]}, 1'b1);
    issue(32'h43);
    rd(8'h40);
    check("rsp in time", rd_val[20], 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(8'h20 + 8'(4 * i));
      check("rsp word", rd_val, i < 2 ? 32'h0 :
        (i == 2 ? 32'h389 : 32'hABCDEF01));
    end
    issue(32'h0);
    rd(8'h40);
    check("no rsp", rd_val[20], 1'b0);
    issue(32'h100);
    check("init clocks", lat inside {[74:80]}, 1'b1);
  endtask
  task t_xfer;
    wr(8'h08, 32'h2F);
    issue(32'h00150011);
    check("start pulse", n_start, 1);
    check("xfer", {transfer_action, transfer_direction, transfer_kind},
      5'h0E);
    blk;
    repeat (1900) @(posedge core_clk);
    rd(8'h40);
    check("data timeout", rd_val[22], 1'b0);
    repeat (60) @(posedge core_clk);
    rd(8'h40);
    check("data timeout", rd_val[22], 1'b1);
    s = start_cnt;
    wr(8'h14, 32'h00010A80);
    repeat (300) @(posedge core_clk);
    check("sync held", start_cnt, s);
    blk;
    rdy;
    check("sync sent", start_cnt, s + 1);
    check("start pulse", n_start, 2);
  endtask
  task t_dma;
    for (int m = 1; m >= 0; m--) begin
      wr(8'h04, {16'h0120, m[0], 15'h0002});
      @(posedge core_clk);
      data_underrun <= 1'b1;
      data_overrun <= 1'b1;
      @(posedge core_clk);
      data_underrun <= 1'b0;
      data_overrun <= 1'b0;
      rd(8'h40);
      check("run flags", rd_val[31:30], m ? 2'h0 : 2'h3);
    end
    for (int i = 1; i < 5; i++) begin
      @(posedge core_clk);
      rx_byte <= 8'(8'h11 * i);
      rx_byte_valid <= 1'b1;
      @(posedge core_clk);
      rx_byte_valid <= 1'b0;
    end
    rd(8'h30);
    check("rx word", rd_val, 32'h11223344);
  endtask
  task t_lock;
    s = start_cnt;
    wr(8'h14, 32'h400);
    repeat (600) @(posedge core_clk);
    wr(8'h14, 32'h3);
    repeat (600) @(posedge core_clk);
    check("locked", start_cnt, s + 1);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(8'h04);
    check("mode reset", rd_val, 32'h0);
    wr(8'h00, 32'h1);
    issue(32'h0);
    check("unlocked", lat <= 4, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_mode;
    t_clk;
    t_cmd;
    t_xfer;
    t_dma;
    t_lock;
    end_sim;
  end
endmodule
